// ---- src/crcc_pkg.sv ----
// crc configuration register block: shared offsets, fields, reset values, state types
// assumes a 32-bit avalon-mm master with byte addresses and byte enables
package crcc_pkg;
	localparam logic [7:0] CRCC_OFF_CTRL  = 8'h00;
	localparam logic [7:0] CRCC_OFF_WLCFG = 8'h04;
	localparam logic [7:0] CRCC_OFF_POLYL = 8'h08;
	localparam logic [7:0] CRCC_OFF_POLYH = 8'h0c;
	localparam logic [7:0] CRCC_OFF_POLYE = 8'h10;

	localparam int CRCC_FIELD_W  = 5;
	localparam int CRCC_WIDTH_LSB = 8;
	localparam int CRCC_LEN_LSB   = 0;
	localparam int CRCC_LOW_LSB   = 1;
	localparam int CRCC_GO_BIT    = 0;
	localparam int CRCC_POLY_W    = 32;

	localparam logic [4:0]  CRCC_CFG_RST  = 5'h00;
	localparam logic [14:0] CRCC_LOW_RST  = 15'h0000;
	localparam logic [15:0] CRCC_HIGH_RST = 16'h0000;
	localparam logic        CRCC_GO_RST   = 1'b0;
	localparam logic [31:0] CRCC_POLY_RST = 32'h0000_0001;
	localparam logic [31:0] CRCC_RD_ZERO  = 32'h0000_0000;

	typedef struct packed {
		logic [4:0]  width;
		logic [4:0]  len;
		logic [14:0] low;
		logic [15:0] high;
		logic        go;
		logic        waitrequest;
		logic [31:0] readdata;
	} crcc_regs_t;

	typedef struct packed {
		logic [31:0] poly;
	} crcc_mask_t;
endpackage

// ---- src/crcc_poly_mask.sv ----
// effective feedback polynomial: length gating and forced x^0 term
// assumes terms and length come from registers in the same clock domain
`timescale 1ns/100ps
module crcc_poly_mask
(
	input  wire logic                clock,
	input  wire logic                arst_n,
	input  wire logic [4:0]          poly_len,
	input  wire logic [31:1]         terms,
	output logic [31:0]              poly
);
	import crcc_pkg::*;

	crcc_mask_t  st;
	crcc_mask_t  next_st;
	logic [31:1] keep;

	genvar i;
	generate
		for (i = 1; i < CRCC_POLY_W; i++)
		begin : g_keep
			assign keep[i] = (i <= int'(poly_len)) && terms[i];
		end
	endgenerate

	always_comb
	begin
		next_st.poly = {keep, 1'b1};
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			st <= '{poly: CRCC_POLY_RST};
		else
			st <= next_st;
	end

	assign poly = st.poly;
endmodule

// ---- src/crcc_cfg_regs.sv ----
// crc configuration registers behind an avalon-mm slave with waitrequest
// assumes byte addresses, one aligned 32-bit word per register, 100 mhz clock
`timescale 1ns/100ps
module crcc_cfg_regs
#(
	parameter int ADDR_W = 8
)
(
	input  wire logic                clock,
	input  wire logic                arst_n,
	input  wire logic [ADDR_W-1:0]   address,
	input  wire logic                read,
	input  wire logic                write,
	input  wire logic [3:0]          byteenable,
	input  wire logic [31:0]         writedata,
	output logic [31:0]              readdata,
	output logic                     waitrequest,
	output logic [4:0]               data_word_width_cfg,
	output logic [4:0]               poly_length_cfg,
	output logic                     shifter_go,
	output logic [31:0]              poly_terms
);
	import crcc_pkg::*;

	generate
		if (ADDR_W < 5 || ADDR_W > 8)
		begin : g_bad_addr
			$error("crcc_cfg_regs: ADDR_W must lie between 5 and 8");
		end
	endgenerate

	crcc_regs_t  st;
	crcc_regs_t  next_st;
	logic [31:0] poly_eff;
	logic        take;
	logic        hit_ctrl;
	logic        hit_wl;
	logic        hit_lo;
	logic        hit_hi;
	logic        hit_eff;
	logic [15:0] wl_view;
	logic [15:0] lo_view;
	logic [15:0] wl_new;
	logic [15:0] lo_new;
	logic [15:0] hi_new;

	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [31:0] wd,
		input logic [3:0]  be
	);
		logic [15:0] m;
		m[7:0]  = be[0] ? wd[7:0] : old[7:0];
		m[15:8] = be[1] ? wd[15:8] : old[15:8];
		return m;
	endfunction

	assign hit_ctrl = address == ADDR_W'(CRCC_OFF_CTRL);
	assign hit_wl   = address == ADDR_W'(CRCC_OFF_WLCFG);
	assign hit_lo   = address == ADDR_W'(CRCC_OFF_POLYL);
	assign hit_hi   = address == ADDR_W'(CRCC_OFF_POLYH);
	assign hit_eff  = address == ADDR_W'(CRCC_OFF_POLYE);

	// a request completes on the edge where waitrequest is seen low
	assign take = write && !read && !st.waitrequest;

	// unimplemented bits are zero in the view, so reads and merges never carry them
	assign wl_view = {3'h0, st.width, 3'h0, st.len};
	assign lo_view = {st.low, 1'b0};
	assign wl_new  = merge16(wl_view, writedata, byteenable);
	assign lo_new  = merge16(lo_view, writedata, byteenable);
	assign hi_new  = merge16(st.high, writedata, byteenable);

	always_comb
	begin
		next_st = st;
		// one wait cycle per request, then waitrequest returns high
		next_st.waitrequest = !((read || write) && st.waitrequest);
		if ((read || write) && st.waitrequest)
		begin
			if (read && hit_ctrl)
				next_st.readdata = {31'h0, st.go};
			else if (read && hit_wl)
				next_st.readdata = {16'h0, wl_view};
			else if (read && hit_lo)
				next_st.readdata = {16'h0, lo_view};
			else if (read && hit_hi)
				next_st.readdata = {16'h0, st.high};
			else if (read && hit_eff)
				next_st.readdata = poly_eff;
			else
				next_st.readdata = CRCC_RD_ZERO;
		end
		if (take && hit_ctrl && byteenable[0])
			next_st.go = writedata[CRCC_GO_BIT];
		if (take && hit_wl)
		begin
			next_st.width = wl_new[CRCC_WIDTH_LSB +: CRCC_FIELD_W];
			next_st.len   = wl_new[CRCC_LEN_LSB +: CRCC_FIELD_W];
		end
		if (take && hit_lo)
			next_st.low = lo_new[15:CRCC_LOW_LSB];
		if (take && hit_hi)
			next_st.high = hi_new;
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			st <= '{width: CRCC_CFG_RST, len: CRCC_CFG_RST, low: CRCC_LOW_RST,
				high: CRCC_HIGH_RST, go: CRCC_GO_RST, waitrequest: 1'b1,
				readdata: CRCC_RD_ZERO};
		else
			st <= next_st;
	end

	crcc_poly_mask u_mask
	(
		.clock    (clock),
		.arst_n   (arst_n),
		.poly_len (st.len),
		.terms    ({st.high, st.low}),
		.poly     (poly_eff)
	);

	assign readdata            = st.readdata;
	assign waitrequest         = st.waitrequest;
	assign data_word_width_cfg = st.width;
	assign poly_length_cfg     = st.len;
	assign shifter_go          = st.go;
	assign poly_terms          = poly_eff;

	// checks
	default clocking cb @(posedge clock);
	endclocking

	default disable iff (!arst_n);

	// a write accepted with both low byte lanes enabled
	sequence s_wr(logic hit);
		write && !read && !waitrequest && hit && byteenable[1:0] == 2'h3;
	endsequence

	// a read request on its first, waiting cycle
	sequence s_rd_req(logic hit);
		read && waitrequest && hit;
	endsequence

	chk_width_write: assert property (s_wr(hit_wl) |=>
		data_word_width_cfg == $past(writedata[12:8]))
		else $error("data word width not taken from bits 12:8");

	chk_len_write: assert property (s_wr(hit_wl) |=>
		poly_length_cfg == $past(writedata[4:0]))
		else $error("polynomial length not taken from bits 4:0");

	// term checks look one cycle later, behind the mask register
	chk_low_terms: assert property (s_wr(hit_lo) ##1 waitrequest |=>
		poly_terms[15:1] == ($past(writedata[15:1], 2)
		& 15'((32'hffff_ffff >> (5'h1f - $past(poly_length_cfg))) >> 1)))
		else $error("low term enables not applied");

	chk_low_bit0: assert property (s_rd_req(hit_lo) |=> !waitrequest && readdata[0] == 1'b0)
		else $error("low term bit 0 read nonzero");

	chk_cfg_reserved: assert property (s_rd_req(hit_wl) |=>
		!waitrequest && readdata[31:13] == 19'h0 && readdata[7:5] == 3'h0)
		else $error("reserved config bits read nonzero");

	chk_reset_zero: assert property ($rose(arst_n) |->
		data_word_width_cfg == 5'h00 && poly_length_cfg == 5'h00
		&& poly_terms == 32'h0000_0001 && !shifter_go)
		else $error("configuration not cleared by reset");

	chk_high_write: assert property (s_wr(hit_hi) ##1 (poly_length_cfg == 5'h1f)[*2] |->
		poly_terms[31:16] == $past(writedata[15:0], 2))
		else $error("high term enables not applied");

	chk_go_follow: assert property (write && !waitrequest && hit_ctrl && byteenable[0]
		|=> shifter_go == $past(writedata[0]))
		else $error("shifter go does not follow the write");

	chk_go_hold: assert property (!(write && !waitrequest && hit_ctrl) |=> $stable(shifter_go))
		else $error("shifter go changed without a write");

	chk_poly_x0: assert property ($stable(poly_length_cfg) |=>
		poly_terms[0] && (poly_terms >> ($past(poly_length_cfg) + 6'h1)) == 32'h0)
		else $error("x0 term missing or terms above length kept");

	chk_wait_cycle: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("waitrequest handshake broken");

	// readback: data stands in the cycle where waitrequest is low
	chk_ctrl_read: assert property (s_rd_req(hit_ctrl) |=>
		!waitrequest && readdata == {31'h0, $past(shifter_go)})
		else $error("control readback differs from shifter go");

	chk_width_read: assert property (s_rd_req(hit_wl) |=>
		!waitrequest && readdata[12:8] == $past(data_word_width_cfg))
		else $error("data word width readback wrong");

	chk_len_read: assert property (s_rd_req(hit_wl) |=>
		!waitrequest && readdata[4:0] == $past(poly_length_cfg))
		else $error("polynomial length readback wrong");

	chk_high_upper: assert property (s_rd_req(hit_hi) |=>
		!waitrequest && readdata[31:16] == 16'h0)
		else $error("high term register upper half read nonzero");

	chk_low_upper: assert property (s_rd_req(hit_lo) |=>
		!waitrequest && readdata[31:16] == 16'h0)
		else $error("low term register upper half read nonzero");

	chk_eff_read: assert property (s_rd_req(hit_eff) |=>
		!waitrequest && readdata == $past(poly_terms))
		else $error("effective polynomial readback wrong");

	chk_unmapped_read: assert property (read && waitrequest
		&& !(hit_ctrl || hit_wl || hit_lo || hit_hi || hit_eff) |=> readdata == 32'h0)
		else $error("unmapped address read nonzero");

	// fields move only on an accepted write, and reset leaves the bus idle
	chk_cfg_hold: assert property (!(write && !waitrequest && hit_wl) |=>
		$stable(data_word_width_cfg) && $stable(poly_length_cfg))
		else $error("width or length changed without a write");

	chk_reset_bus: assert property ($rose(arst_n) |-> waitrequest && readdata == 32'h0)
		else $error("bus outputs not idle after reset");
endmodule

// ---- dv/tb_crc_width_and_polynomial_config.sv ----
// self-checking bench for the crc width, length and polynomial term registers
// assumes crcc_cfg_regs answers each avalon request after one wait cycle
`timescale 1ns/100ps
module tb_crc_width_and_polynomial_config;
	import crcc_pkg::*;
	typedef struct packed {
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] data;
		logic [3:0]  be;
	} crcc_row_t;
	logic        clock      = 1'b0;
	logic        arst_n     = 1'b0;
	logic [7:0]  address    = 8'h00;
	logic        read       = 1'b0;
	logic        write      = 1'b0;
	logic [3:0]  byteenable = 4'h0;
	logic [31:0] writedata  = 32'h0;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [4:0]  data_word_width_cfg;
	logic [4:0]  poly_length_cfg;
	logic        shifter_go;
	logic [31:0] poly_terms;
	logic [31:0] rd;
	int          n_errors = 0;
	int          checks   = 0;
	int          cycles   = 0;
	// reads carry the expected word in the data field
	localparam crcc_row_t rows [20] = '{
		{1'b1, CRCC_OFF_WLCFG, 32'hffff_ffff, 4'hf}, {1'b0, CRCC_OFF_WLCFG, 32'h0000_1f1f, 4'h0},
		{1'b1, CRCC_OFF_POLYL, 32'hffff_ffff, 4'hf}, {1'b0, CRCC_OFF_POLYL, 32'h0000_fffe, 4'h0},
		{1'b1, CRCC_OFF_POLYH, 32'hffff_ffff, 4'hf}, {1'b0, CRCC_OFF_POLYH, 32'h0000_ffff, 4'h0},
		{1'b0, CRCC_OFF_POLYE, 32'hffff_ffff, 4'h0}, {1'b1, CRCC_OFF_WLCFG, 32'h0000_0a05, 4'h1},
		{1'b0, CRCC_OFF_WLCFG, 32'h0000_1f05, 4'h0}, {1'b1, CRCC_OFF_POLYL, 32'h0000_1235, 4'h3},
		{1'b0, CRCC_OFF_POLYL, 32'h0000_1234, 4'h0}, {1'b0, CRCC_OFF_POLYE, 32'h0000_0035, 4'h0},
		{1'b1, CRCC_OFF_POLYE, 32'h1234_5678, 4'hf}, {1'b0, CRCC_OFF_POLYE, 32'h0000_0035, 4'h0},
		{1'b1, 8'h14,          32'hffff_ffff, 4'hf}, {1'b0, 8'h14,          32'h0000_0000, 4'h0},
		{1'b1, CRCC_OFF_CTRL,  32'h0000_0001, 4'hf}, {1'b0, CRCC_OFF_CTRL,  32'h0000_0001, 4'h0},
		{1'b1, CRCC_OFF_CTRL,  32'h0000_0000, 4'hf}, {1'b0, CRCC_OFF_CTRL,  32'h0000_0000, 4'h0}
	};

	crcc_cfg_regs DUT
	(
		.clock               (clock),
		.arst_n              (arst_n),
		.address             (address),
		.read                (read),
		.write               (write),
		.byteenable          (byteenable),
		.writedata           (writedata),
		.readdata            (readdata),
		.waitrequest         (waitrequest),
		.data_word_width_cfg (data_word_width_cfg),
		.poly_length_cfg     (poly_length_cfg),
		.shifter_go          (shifter_go),
		.poly_terms          (poly_terms)
	);

	always #5 clock = ~clock;

	task automatic report_and_stop();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// a hang counts as a mismatch
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			n_errors = n_errors + 1;
			report_and_stop();
		end
	end

	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		checks = checks + 1;
		if (got !== exp)
		begin
			n_errors = n_errors + 1;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// request held until waitrequest is sampled low, then released
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] b);
		@(posedge clock);
		read       <= ~wr;
		write      <= wr;
		address    <= a;
		writedata  <= d;
		byteenable <= b;
		do
			@(posedge clock);
		while (waitrequest !== 1'b0);
		rd = readdata;
		read  <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic settle();
		repeat (2) @(posedge clock);
		#1;
	endtask

	initial
	begin
		repeat (6) @(posedge clock);
		arst_n <= 1'b1;
		foreach (rows[i])
		begin
			bus(rows[i].wr, rows[i].addr, rows[i].data, rows[i].be);
			if (!rows[i].wr)
				compare(rd, rows[i].data);
		end
		bus(1'b1, CRCC_OFF_WLCFG, 32'h0000_0c07, 4'hf);
		settle();
		compare({27'h0, data_word_width_cfg}, 32'h0000_000c);
		compare({27'h0, poly_length_cfg}, 32'h0000_0007);
		compare(poly_terms, 32'h0000_0035);
		bus(1'b1, CRCC_OFF_CTRL, 32'h0000_0001, 4'hf);
		settle();
		compare({31'h0, shifter_go}, 32'h0000_0001);
		bus(1'b1, CRCC_OFF_CTRL, 32'h0000_0000, 4'hf);
		settle();
		compare({31'h0, shifter_go}, 32'h0000_0000);
		// second reset in mid-run clears everything again
		bus(1'b1, CRCC_OFF_CTRL, 32'h0000_0001, 4'hf);
		@(posedge clock);
		arst_n <= 1'b0;
		settle();
		compare({21'h0, data_word_width_cfg, poly_length_cfg, shifter_go}, 32'h0);
		compare(poly_terms, 32'h0000_0001);
		@(posedge clock);
		arst_n <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			bus(1'b0, 8'(4 * i), 32'h0, 4'h0);
			compare(rd, (i == 4) ? 32'h0000_0001 : 32'h0000_0000);
		end
		report_and_stop();
	end
endmodule
